/* File: hw/csa_pkg.sv */
package csa_pkg;

    // Special-function addresses
    localparam logic [15:0] AUX_ADDR = 16'hFE02;
    localparam logic [15:0] STATUS_ADDR = 16'hFE06;
    localparam logic [15:0] STKL_ADDR = 16'hFE0A;
    localparam logic [15:0] STKH_ADDR = 16'hFE0B;

    // Reset values
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] STK_RESET = 16'h0000;

    // Status word bit positions
    localparam int CARRY_BIT = 7;
    localparam int HALF_BIT = 6;
    localparam int UHI_BIT = 5;
    localparam int ULO_BIT = 4;
    localparam int BNK_BIT = 3;
    localparam int RANGE_BIT = 2;
    localparam int NINTH_BIT = 1;
    localparam int PAR_BIT = 0;

    // Data space areas
    localparam logic [7:0] SYS_PAGE = 8'hFF;
    localparam logic [7:0] SFR_PAGE = 8'hFE;
    localparam logic [15:0] RAM_TOP = 16'hFDFF;
    localparam logic [7:0] BLANK_READ = 8'hFF;

    // Pointer registers in low RAM
    localparam int PTR_COUNT = 64;
    localparam int LOW_RAM_DEPTH = 128;

    typedef enum logic [2:0] {
        FLG_NONE = 3'd0,
        FLG_ADD = 3'd1,
        FLG_SUB = 3'd2,
        FLG_CMP = 3'd3,
        FLG_ROT = 3'd4,
        FLG_MUL = 3'd5,
        FLG_DIV = 3'd6
    } csa_flag_op_t;

    typedef enum logic [1:0] {
        AGEN_PLAIN = 2'd0,
        AGEN_AUX = 2'd1,
        AGEN_OFF7 = 2'd2
    } csa_agen_mode_t;

    typedef enum logic [2:0] {
        STK_IDLE = 3'b000,
        STK_RET_LO = 3'b001,
        STK_RET_HCAP = 3'b011,
        STK_RET_LCAP = 3'b010,
        STK_CALL_HI = 3'b100
    } csa_stk_state_t;

endpackage : csa_pkg

/* File: hw/csa_core_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Auxiliary operand register is 8-bit R/W at FE02H, reset to zero.
// RULE_02: Multiply and divide place part of their result in the auxiliary register.
// RULE_03: Auxiliary register used as offset is signed, -128 to +127.
// RULE_04: Status word at FE06H, reset zero: carry, half carry, user bits, bank, range, ninth, parity.
// RULE_05: Carry set by add carry, sub/compare borrow, rotate carry-out; else cleared.
// RULE_06: Half carry set on carry or borrow at bit 3; else cleared.
// RULE_07: Status bits 5 and 4 are free user bits without side effect.
// RULE_08: Bank bit picks table ROM half: 0 low 128K, 1 high 128K.
// RULE_09: Overflow set when signed add or subtract gives wrong sign.
// RULE_10: Overflow also set on nonzero multiply high part or zero divisor.
// RULE_11: Status bit 1 is ninth data bit of RAM 0000H to FDFFH.
// RULE_12: Status bit 0 always shows accumulator odd parity.
// RULE_13: Stack pointer is 16 bits, low at FE0A, high at FE0B, reset 0000H.
// RULE_14: Stack pre-increments before each write, post-decrements after each read.
// RULE_15: Call pushes bank plus low byte then high; return pops reverse order.
// RULE_16: Stack lives in RAM area 0000H to FDFFH; the stack pointer is not bounded and can address FE00H and above.
// RULE_17: Sixty-four pointer registers are byte pairs in RAM 0 to 7FH.
// RULE_18: Plain indirect mode uses selected pointer as operand address.
// RULE_19: Offset mode adds sign-extended auxiliary register to pointer.
// RULE_20: Areas are system FF00H+, special-function FE00H+, RAM below; base decides.
// RULE_21: RAM base plus offset leaving RAM area reads 0FFH, no SFR access.
// RULE_22: Special-function base plus offset wraps within the FE page.
// RULE_23: Pointer zero plus 7-bit signed offset follows the same area rules.
module csa_core_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Special-function register port
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Datapath flag inputs
    input wire logic [7:0] acc_value,
    input wire csa_pkg::csa_flag_op_t flag_op,
    input wire logic [7:0] flag_a,
    input wire logic [7:0] flag_b,
    input wire logic flag_cin,
    input wire logic rot_carry,
    input wire logic [15:0] mul_high,
    input wire logic [15:0] div_divisor,
    input wire logic ninth_we,
    input wire logic ninth_value,
    input wire logic md_we,
    input wire logic [7:0] md_aux,
    // Status outputs
    output logic [7:0] status_word,
    output logic [7:0] aux_operand,
    output logic [15:0] stack_ptr,
    // Table read
    input wire logic [16:0] table_read_word,
    output logic [17:0] table_rom_addr,
    // Stack requests
    input wire logic stk_push,
    input wire logic stk_pop,
    input wire logic [8:0] stk_push_data,
    input wire logic stk_call,
    input wire logic [16:0] call_ret_addr,
    input wire logic code_bank_bit,
    input wire logic stk_ret,
    output logic stk_busy,
    output logic [15:0] stk_addr,
    output logic [8:0] stk_wdata,
    output logic stk_we,
    output logic stk_re,
    input wire logic [8:0] stk_rdata,
    output logic [16:0] ret_addr,
    output logic ret_bank,
    output logic ret_valid,
    // Low RAM byte port
    input wire logic low_we,
    input wire logic [6:0] low_addr,
    input wire logic [8:0] low_wdata,
    output logic [8:0] low_rdata,
    // Address generation
    input wire logic agen_valid,
    input wire csa_pkg::csa_agen_mode_t agen_mode,
    input wire logic [5:0] agen_ptr_sel,
    input wire logic [6:0] agen_off7,
    output logic [15:0] agen_addr,
    output logic agen_blank,
    output logic agen_done
);

    logic [7:0] aux_operand_reg;
    logic [7:0] status_word_reg;
    logic [15:0] stack_ptr_reg;
    logic [8:0] low_ram_reg [csa_pkg::LOW_RAM_DEPTH];
    logic [15:0] ptr_reg_n [csa_pkg::PTR_COUNT];
    csa_pkg::csa_stk_state_t stk_state_reg;
    logic [8:0] call_hi_reg;
    logic [8:0] ret_hi_reg;
    logic [8:0] sum9;
    logic [8:0] diff9;
    logic [4:0] half_sum;
    logic [4:0] half_diff;
    logic [7:0] flags_next;
    logic sw_status;
    logic stk_idle;
    logic [15:0] agen_base;
    logic [16:0] agen_off_ext;
    logic [16:0] agen_sum;

    assign sw_status = sfr_wr && (sfr_addr == csa_pkg::STATUS_ADDR);
    assign stk_idle = (stk_state_reg == csa_pkg::STK_IDLE);

    // RULE_01 aux register write
    // RULE_02 muldiv result wins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_operand_reg <= csa_pkg::AUX_RESET;
        end else if (md_we) begin
            aux_operand_reg <= md_aux;
        end else if (sfr_wr && (sfr_addr == csa_pkg::AUX_ADDR)) begin
            aux_operand_reg <= sfr_wdata;
        end
    end

    // Flag arithmetic
    always_comb begin
        sum9 = {1'b0, flag_a} + {1'b0, flag_b} + {8'h00, flag_cin};
        diff9 = {1'b0, flag_a} - {1'b0, flag_b} - {8'h00, flag_cin};
        half_sum = {1'b0, flag_a[3:0]} + {1'b0, flag_b[3:0]} + {4'h0, flag_cin};
        half_diff = {1'b0, flag_a[3:0]} - {1'b0, flag_b[3:0]} - {4'h0, flag_cin};
        flags_next = status_word_reg;
        if (sw_status) begin
            flags_next = sfr_wdata;
        end
        case (flag_op)
            // RULE_05 carry and borrow
            // RULE_06 half carry
            // RULE_09 signed overflow
            csa_pkg::FLG_ADD: begin
                flags_next[csa_pkg::CARRY_BIT] = sum9[8];
                flags_next[csa_pkg::HALF_BIT] = half_sum[4];
                flags_next[csa_pkg::RANGE_BIT] = (flag_a[7] == flag_b[7]) && (sum9[7] != flag_a[7]);
            end
            csa_pkg::FLG_SUB: begin
                flags_next[csa_pkg::CARRY_BIT] = diff9[8];
                flags_next[csa_pkg::HALF_BIT] = half_diff[4];
                flags_next[csa_pkg::RANGE_BIT] = (flag_a[7] != flag_b[7]) && (diff9[7] != flag_a[7]);
            end
            csa_pkg::FLG_CMP: begin
                flags_next[csa_pkg::CARRY_BIT] = diff9[8];
            end
            csa_pkg::FLG_ROT: begin
                flags_next[csa_pkg::CARRY_BIT] = rot_carry;
            end
            // RULE_10 multiply and divide range
            csa_pkg::FLG_MUL: begin
                flags_next[csa_pkg::RANGE_BIT] = (mul_high != 16'h0000);
            end
            csa_pkg::FLG_DIV: begin
                flags_next[csa_pkg::RANGE_BIT] = (div_divisor == 16'h0000);
            end
            default: begin
            end
        endcase
        // RULE_11 ninth bit transfer
        if (ninth_we) begin
            flags_next[csa_pkg::NINTH_BIT] = ninth_value;
        end
        // RULE_12 parity tracks accumulator
        flags_next[csa_pkg::PAR_BIT] = ^acc_value;
    end

    // RULE_04 status word register
    // RULE_07 user bits only by write
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_word_reg <= csa_pkg::STATUS_RESET;
        end else begin
            status_word_reg <= flags_next;
        end
    end

    // RULE_08 table bank select
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            table_rom_addr <= 18'h0_0000;
        end else begin
            table_rom_addr <= {status_word_reg[csa_pkg::BNK_BIT], table_read_word};
        end
    end

    // Register read port, unmapped reads zero
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else if (sfr_rd) begin
            sfr_hit <= 1'b1;
            if (sfr_addr == csa_pkg::AUX_ADDR) begin
                sfr_rdata <= aux_operand_reg;
            end else if (sfr_addr == csa_pkg::STATUS_ADDR) begin
                sfr_rdata <= status_word_reg;
            end else if (sfr_addr == csa_pkg::STKL_ADDR) begin
                sfr_rdata <= stack_ptr_reg[7:0];
            end else if (sfr_addr == csa_pkg::STKH_ADDR) begin
                sfr_rdata <= stack_ptr_reg[15:8];
            end else begin
                sfr_rdata <= 8'h00;
                sfr_hit <= 1'b0;
            end
        end else begin
            sfr_hit <= 1'b0;
        end
    end

    // Stack engine; a stack operation beats a software pointer write
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stk_state_reg <= csa_pkg::STK_IDLE;
            stack_ptr_reg <= csa_pkg::STK_RESET;
            stk_addr <= 16'h0000;
            stk_wdata <= 9'h000;
            stk_we <= 1'b0;
            stk_re <= 1'b0;
            stk_busy <= 1'b0;
            call_hi_reg <= 9'h000;
            ret_hi_reg <= 9'h000;
            ret_addr <= 17'h0_0000;
            ret_bank <= 1'b0;
            ret_valid <= 1'b0;
        end else begin
            stk_we <= 1'b0;
            stk_re <= 1'b0;
            ret_valid <= 1'b0;
            case (stk_state_reg)
                csa_pkg::STK_IDLE: begin
                    // RULE_15 call pushes bank and low first
                    // RULE_14 pre-increment on write
                    if (stk_call) begin
                        stack_ptr_reg <= stack_ptr_reg + 16'h0001;
                        stk_addr <= stack_ptr_reg + 16'h0001;
                        stk_wdata <= {code_bank_bit, call_ret_addr[7:0]};
                        stk_we <= 1'b1;
                        call_hi_reg <= call_ret_addr[16:8];
                        stk_state_reg <= csa_pkg::STK_CALL_HI;
                        stk_busy <= 1'b1;
                    end else if (stk_ret) begin
                        // RULE_15 return pops high first
                        stk_addr <= stack_ptr_reg;
                        stk_re <= 1'b1;
                        stack_ptr_reg <= stack_ptr_reg - 16'h0001;
                        stk_state_reg <= csa_pkg::STK_RET_LO;
                        stk_busy <= 1'b1;
                    end else if (stk_push) begin
                        stack_ptr_reg <= stack_ptr_reg + 16'h0001;
                        stk_addr <= stack_ptr_reg + 16'h0001;
                        stk_wdata <= stk_push_data;
                        stk_we <= 1'b1;
                    end else if (stk_pop) begin
                        // RULE_14 post-decrement on read
                        stk_addr <= stack_ptr_reg;
                        stk_re <= 1'b1;
                        stack_ptr_reg <= stack_ptr_reg - 16'h0001;
                    end else if (sfr_wr && (sfr_addr == csa_pkg::STKL_ADDR)) begin
                        // RULE_13 pointer byte writes
                        stack_ptr_reg[7:0] <= sfr_wdata;
                    end else if (sfr_wr && (sfr_addr == csa_pkg::STKH_ADDR)) begin
                        stack_ptr_reg[15:8] <= sfr_wdata;
                    end
                end
                csa_pkg::STK_CALL_HI: begin
                    stack_ptr_reg <= stack_ptr_reg + 16'h0001;
                    stk_addr <= stack_ptr_reg + 16'h0001;
                    stk_wdata <= call_hi_reg;
                    stk_we <= 1'b1;
                    stk_state_reg <= csa_pkg::STK_IDLE;
                    stk_busy <= 1'b0;
                end
                csa_pkg::STK_RET_LO: begin
                    stk_addr <= stack_ptr_reg;
                    stk_re <= 1'b1;
                    stack_ptr_reg <= stack_ptr_reg - 16'h0001;
                    stk_state_reg <= csa_pkg::STK_RET_HCAP;
                end
                csa_pkg::STK_RET_HCAP: begin
                    ret_hi_reg <= stk_rdata;
                    stk_state_reg <= csa_pkg::STK_RET_LCAP;
                end
                csa_pkg::STK_RET_LCAP: begin
                    ret_addr <= {ret_hi_reg, stk_rdata[7:0]};
                    ret_bank <= stk_rdata[8];
                    ret_valid <= 1'b1;
                    stk_state_reg <= csa_pkg::STK_IDLE;
                    stk_busy <= 1'b0;
                end
                default: begin
                    stk_state_reg <= csa_pkg::STK_IDLE;
                    stk_busy <= 1'b0;
                end
            endcase
        end
    end

    // RULE_17 low RAM holds the pointer pairs
    always_ff @(posedge ref_clk) begin
        if (low_we) begin
            low_ram_reg[low_addr] <= low_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_rdata <= 9'h000;
        end else begin
            low_rdata <= low_ram_reg[low_addr];
        end
    end

    // RULE_17 pointer n is bytes 2n and 2n+1
    genvar gi;
    generate
        for (gi = 0; gi < csa_pkg::PTR_COUNT; gi++) begin : g_ptr
            assign ptr_reg_n[gi] = {low_ram_reg[2 * gi + 1][7:0], low_ram_reg[2 * gi][7:0]};
        end
    endgenerate

    // Operand address formation
    always_comb begin
        agen_base = ptr_reg_n[agen_ptr_sel];
        agen_off_ext = 17'h0_0000;
        case (agen_mode)
            // RULE_03 signed auxiliary offset
            // RULE_19 pointer plus auxiliary
            csa_pkg::AGEN_AUX: begin
                agen_off_ext = {{9{aux_operand_reg[7]}}, aux_operand_reg};
            end
            // RULE_23 pointer zero plus 7-bit offset
            csa_pkg::AGEN_OFF7: begin
                agen_base = ptr_reg_n[0];
                agen_off_ext = {{10{agen_off7[6]}}, agen_off7};
            end
            // RULE_18 plain pointer
            default: begin
                agen_off_ext = 17'h0_0000;
            end
        endcase
        agen_sum = {1'b0, agen_base} + agen_off_ext;
    end

    // RULE_20 base decides the area
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            agen_addr <= 16'h0000;
            agen_blank <= 1'b0;
            agen_done <= 1'b0;
        end else begin
            agen_done <= agen_valid;
            if (agen_valid) begin
                if (agen_base[15:8] == csa_pkg::SYS_PAGE) begin
                    agen_addr <= {csa_pkg::SYS_PAGE, agen_sum[7:0]};
                    agen_blank <= 1'b0;
                end else if (agen_base[15:8] == csa_pkg::SFR_PAGE) begin
                    // RULE_22 wrap within the page
                    agen_addr <= {csa_pkg::SFR_PAGE, agen_sum[7:0]};
                    agen_blank <= 1'b0;
                end else begin
                    // RULE_21 leaving RAM reads blank
                    // RULE_16 RAM area bound, for operands only; the stack pointer is not bounded
                    agen_addr <= agen_sum[15:0];
                    agen_blank <= agen_sum[16] || (agen_sum[15:0] > csa_pkg::RAM_TOP);
                end
            end
        end
    end

    assign status_word = status_word_reg;
    assign aux_operand = aux_operand_reg;
    assign stack_ptr = stack_ptr_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_call_req;
        stk_call && stk_idle;
    endsequence

    sequence s_two_writes;
        stk_we ##1 stk_we;
    endsequence

    a_aux_sw_write: assert property ( // RULE_01
        (sfr_wr && sfr_addr == csa_pkg::AUX_ADDR && !md_we) |=> aux_operand == $past(sfr_wdata))
        else $error("aux write lost");
    a_aux_muldiv: assert property ( // RULE_02
        md_we |=> aux_operand == $past(md_aux))
        else $error("muldiv result not in aux");
    a_parity_track: assert property ( // RULE_12
        ##1 status_word[0] == ^$past(acc_value))
        else $error("parity wrong");
    a_carry_add: assert property ( // RULE_05
        flag_op == csa_pkg::FLG_ADD |=> status_word[7] == $past(sum9[8]))
        else $error("add carry wrong");
    a_div_range: assert property ( // RULE_10
        (flag_op == csa_pkg::FLG_DIV && div_divisor == 16'h0000) |=> status_word[2])
        else $error("zero divisor not flagged");
    a_push_inc: assert property ( // RULE_14
        (stk_push && stk_idle && !stk_call && !stk_ret) |=> stack_ptr == $past(stack_ptr) + 16'h0001 && stk_we)
        else $error("push increment wrong");
    a_call_order: assert property ( // RULE_15
        s_call_req |=> s_two_writes ##1 stack_ptr == $past(stack_ptr, 3) + 16'h0002)
        else $error("call sequence wrong");
    a_ret_bound: assert property ( // RULE_15
        (stk_ret && stk_idle && !stk_call) |-> ##4 ret_valid)
        else $error("return not done");
    a_ram_closed: assert property ( // RULE_21
        (agen_valid && agen_base < 16'hFE00 && agen_sum > 17'h0_FDFF) |=> agen_blank)
        else $error("RAM overrun not blanked");
    a_sfr_wrap: assert property ( // RULE_22
        (agen_valid && agen_base[15:8] == 8'hFE) |=> agen_addr[15:8] == 8'hFE && !agen_blank)
        else $error("SFR wrap wrong");
    a_bank_select: assert property ( // RULE_08
        ##1 table_rom_addr[17] == $past(status_word[3]))
        else $error("bank select wrong");

endmodule : csa_core_regs

/* File: verification/csa_core_regs_tb.sv */
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 0;
    logic arst_n = 0;
    logic [15:0] sfr_addr = 0;
    logic sfr_wr = 0, sfr_rd = 0, flag_cin = 0, rot_carry = 0;
    logic [7:0] sfr_wdata = 0, acc_value = 0, flag_a = 0, flag_b = 0, md_aux = 0;
    csa_pkg::csa_flag_op_t flag_op = csa_pkg::FLG_NONE;
    logic ninth_we = 0, ninth_value = 0, md_we = 0, code_bank_bit = 0;
    logic [15:0] mul_high = 0, div_divisor = 16'h0001;
    logic [16:0] table_read_word = 17'h1_0abc, call_ret_addr = 0;
    logic stk_push = 0, stk_pop = 0, stk_call = 0, stk_ret = 0;
    logic [8:0] stk_push_data = 0, stk_rdata = 0, low_wdata = 0;
    logic low_we = 0, agen_valid = 0;
    logic [6:0] low_addr = 0, agen_off7 = 0;
    csa_pkg::csa_agen_mode_t agen_mode = csa_pkg::AGEN_PLAIN;
    logic [5:0] agen_ptr_sel = 0;
    logic [7:0] sfr_rdata, status_word, aux_operand;
    logic sfr_hit, stk_busy, stk_we, stk_re, ret_bank, ret_valid, agen_blank, agen_done;
    logic [15:0] stack_ptr, stk_addr, agen_addr;
    logic [17:0] table_rom_addr;
    logic [8:0] stk_wdata, low_rdata;
    logic [16:0] ret_addr;
    logic [8:0] stack_mem [0:511];
    logic [8:0] lram_init [0:11] = '{9'h0ff, 9'h0fe, 9'h010, 9'h0ff, 9'h000, 9'h000,
                                     9'h123, 9'h101, 9'h000, 9'h000, 9'h0ff, 9'h1fd};
    int n_mismatch = 0;
    int comparisons = 0;
    int i;

    csa_core_regs i_dut (
        .ref_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
        .acc_value, .flag_op, .flag_a, .flag_b, .flag_cin, .rot_carry, .mul_high, .div_divisor,
        .ninth_we, .ninth_value, .md_we, .md_aux, .status_word, .aux_operand, .stack_ptr,
        .table_read_word, .table_rom_addr, .stk_push, .stk_pop, .stk_push_data, .stk_call,
        .call_ret_addr, .code_bank_bit, .stk_ret, .stk_busy, .stk_addr, .stk_wdata, .stk_we,
        .stk_re, .stk_rdata, .ret_addr, .ret_bank, .ret_valid, .low_we, .low_addr, .low_wdata,
        .low_rdata, .agen_valid, .agen_mode, .agen_ptr_sel, .agen_off7, .agen_addr,
        .agen_blank, .agen_done
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Stack RAM, one-cycle read; data toggles when not read so stale values never pass
    always @(posedge ref_clk) begin
        if (stk_we) begin
            stack_mem[stk_addr[8:0]] <= stk_wdata;
        end
        stk_rdata <= stk_re ? stack_mem[stk_addr[8:0]] : ~stk_rdata;
    end

    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic sfr_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask : sfr_write

    task automatic sfr_check(input logic [15:0] a, input logic [7:0] d, input logic hit);
        @(posedge ref_clk);
        {sfr_addr, sfr_rd} <= {a, 1'b1};
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1;
        chk(sfr_rdata, d, "register read data");
        chk(sfr_hit, hit, "register hit");
    endtask : sfr_check

    task automatic flag(input csa_pkg::csa_flag_op_t op, input logic [7:0] a, input logic [7:0] b,
                        input logic rc, input logic [15:0] mh, input logic [15:0] dv, input logic [7:0] e);
        @(posedge ref_clk);
        {flag_a, flag_b, rot_carry, mul_high, div_divisor} <= {a, b, rc, mh, dv};
        flag_op <= op;
        @(posedge ref_clk);
        flag_op <= csa_pkg::FLG_NONE;
        #1;
        chk(status_word, e, "status flags");
    endtask : flag

    task automatic low_wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge ref_clk);
        {low_we, low_addr, low_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        low_we <= 1'b0;
    endtask : low_wr

    task automatic agen(input csa_pkg::csa_agen_mode_t m, input logic [5:0] sel, input logic [6:0] off,
                        input logic [15:0] ea, input logic eb);
        @(posedge ref_clk);
        {agen_valid, agen_ptr_sel, agen_off7} <= {1'b1, sel, off};
        agen_mode <= m;
        @(posedge ref_clk);
        agen_valid <= 1'b0;
        #1;
        chk(agen_done, 1'b1, "agen done");
        chk(agen_blank, eb, "agen blank");
        if (!eb) begin
            chk(agen_addr, ea, "agen address");
        end
    endtask : agen

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        sfr_check(csa_pkg::AUX_ADDR, 8'h00, 1'b1);
        sfr_check(csa_pkg::STATUS_ADDR, 8'h00, 1'b1);
        sfr_check(csa_pkg::STKL_ADDR, 8'h00, 1'b1);
        sfr_check(csa_pkg::STKH_ADDR, 8'h00, 1'b1);
        sfr_check(16'hfe03, 8'h00, 1'b0);
        sfr_write(csa_pkg::AUX_ADDR, 8'ha5);
        sfr_check(csa_pkg::AUX_ADDR, 8'ha5, 1'b1);
        sfr_write(csa_pkg::STATUS_ADDR, 8'h39);
        sfr_check(csa_pkg::STATUS_ADDR, 8'h38, 1'b1);
        chk(table_rom_addr, 18'h3_0abc, "table bank high");
        sfr_write(csa_pkg::STATUS_ADDR, 8'h00);
        @(posedge ref_clk);
        #1;
        chk(table_rom_addr, 18'h1_0abc, "table bank low");
        acc_value <= 8'h07;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(status_word, 8'h01, "odd parity");
        acc_value <= 8'h03;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(status_word, 8'h00, "even parity");
        flag(csa_pkg::FLG_ADD, 8'h7f, 8'h01, 1'b0, 16'h0000, 16'h0001, 8'h44);
        flag(csa_pkg::FLG_ADD, 8'hff, 8'h01, 1'b0, 16'h0000, 16'h0001, 8'hc0);
        flag(csa_pkg::FLG_SUB, 8'h80, 8'h01, 1'b0, 16'h0000, 16'h0001, 8'h44);
        flag(csa_pkg::FLG_SUB, 8'h00, 8'h01, 1'b0, 16'h0000, 16'h0001, 8'hc0);
        flag(csa_pkg::FLG_CMP, 8'h05, 8'h01, 1'b0, 16'h0000, 16'h0001, 8'h40);
        flag(csa_pkg::FLG_ROT, 8'h05, 8'h01, 1'b1, 16'h0000, 16'h0001, 8'hc0);
        flag(csa_pkg::FLG_MUL, 8'h05, 8'h01, 1'b0, 16'h0001, 16'h0001, 8'hc4);
        flag(csa_pkg::FLG_MUL, 8'h05, 8'h01, 1'b0, 16'h0000, 16'h0001, 8'hc0);
        flag(csa_pkg::FLG_DIV, 8'h05, 8'h01, 1'b0, 16'h0000, 16'h0000, 8'hc4);
        flag(csa_pkg::FLG_DIV, 8'h05, 8'h01, 1'b0, 16'h0000, 16'h0005, 8'hc0);
        flag_cin <= 1'b1;
        flag(csa_pkg::FLG_ADD, 8'hff, 8'h00, 1'b0, 16'h0000, 16'h0005, 8'hc0);
        flag_cin <= 1'b0;
        @(posedge ref_clk);
        {ninth_we, ninth_value, md_we, md_aux} <= {1'b1, 1'b1, 1'b1, 8'h5a};
        @(posedge ref_clk);
        {ninth_we, md_we} <= 2'b00;
        #1;
        chk(status_word, 8'hc2, "ninth bit load");
        chk(aux_operand, 8'h5a, "muldiv aux part");
        @(posedge ref_clk);
        {stk_push, stk_push_data} <= {1'b1, 9'h1a5};
        @(posedge ref_clk);
        stk_push <= 1'b0;
        #1;
        chk({stk_we, stk_wdata, stk_addr}, {1'b1, 9'h1a5, 16'h0001}, "push write");
        chk(stack_ptr, 16'h0001, "push pointer");
        @(posedge ref_clk);
        stk_pop <= 1'b1;
        @(posedge ref_clk);
        stk_pop <= 1'b0;
        #1;
        chk({stk_re, stk_addr}, {1'b1, 16'h0001}, "pop read");
        chk(stack_ptr, 16'h0000, "pop pointer");
        sfr_write(csa_pkg::STKL_ADDR, 8'hff);
        @(posedge ref_clk);
        {stk_call, call_ret_addr, code_bank_bit} <= {1'b1, 17'h1_2345, 1'b1};
        @(posedge ref_clk);
        stk_call <= 1'b0;
        #1;
        chk({stk_busy, stk_we, stk_addr, stk_wdata}, {2'b11, 16'h0100, 9'h145}, "call low");
        @(posedge ref_clk);
        #1;
        chk({stk_we, stk_addr, stk_wdata}, {1'b1, 16'h0101, 9'h123}, "call high");
        sfr_check(csa_pkg::STKH_ADDR, 8'h01, 1'b1);
        @(posedge ref_clk);
        stk_ret <= 1'b1;
        @(posedge ref_clk);
        stk_ret <= 1'b0;
        i = 0;
        while (ret_valid !== 1'b1 && i < 8) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        if (i == 8) begin
            n_mismatch++;
            conclude();
        end
        chk({ret_bank, ret_addr}, {1'b1, 17'h1_2345}, "return value");
        @(posedge ref_clk);
        #1;
        chk(stack_ptr, 16'h00ff, "return pointer");
        for (i = 0; i < 12; i++) begin
            low_wr(i[6:0], lram_init[i]);
        end
        @(posedge ref_clk);
        #1;
        chk(low_rdata, 9'h1fd, "nine bit low ram");
        agen(csa_pkg::AGEN_PLAIN, 6'd3, 7'h00, 16'h0123, 1'b0);
        agen(csa_pkg::AGEN_PLAIN, 6'd1, 7'h00, 16'hff10, 1'b0);
        sfr_write(csa_pkg::AUX_ADDR, 8'h02);
        agen(csa_pkg::AGEN_AUX, 6'd3, 7'h00, 16'h0125, 1'b0);
        agen(csa_pkg::AGEN_AUX, 6'd0, 7'h00, 16'hfe01, 1'b0);
        sfr_write(csa_pkg::AUX_ADDR, 8'h80);
        agen(csa_pkg::AGEN_AUX, 6'd3, 7'h00, 16'h00a3, 1'b0);
        agen(csa_pkg::AGEN_AUX, 6'd2, 7'h00, 16'h0000, 1'b1);
        sfr_write(csa_pkg::AUX_ADDR, 8'h01);
        agen(csa_pkg::AGEN_AUX, 6'd5, 7'h00, 16'h0000, 1'b1);
        agen(csa_pkg::AGEN_OFF7, 6'd9, 7'h7e, 16'hfefd, 1'b0);
        agen(csa_pkg::AGEN_OFF7, 6'd9, 7'h40, 16'hfebf, 1'b0);
        agen(csa_pkg::AGEN_OFF7, 6'd9, 7'h01, 16'hfe00, 1'b0);
        conclude();
    end
endmodule : testbench
